/* pkg/mdfs_map.svh */
`ifndef MDFS_MAP_SVH
`define MDFS_MAP_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define MDFS_REG_CTRL 4'h0
`define MDFS_REG_STATUS 4'h1
`define MDFS_REG_OCP 4'h2
`define MDFS_REG_MISC 4'h3

// ----------------------------------------
// Control fields
// ----------------------------------------
`define MDFS_CTRL_RETRY 0
`define MDFS_CTRL_RECOVER 1
`define MDFS_CTRL_OL_EN 2
`define MDFS_CTRL_WARN_REP 3
`define MDFS_CTRL_CLEAR 4
`define MDFS_CTRL_RESET 4'h0

// ----------------------------------------
// Status byte fields
// ----------------------------------------
`define MDFS_ST_SUPPLY 5
`define MDFS_ST_PUMP 4
`define MDFS_ST_OCP 3
`define MDFS_ST_TEMP 1
`define MDFS_ST_OPEN 0
`define MDFS_ST_ONES 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define MDFS_CLK_MHZ 100
`define MDFS_CYC_UP(ns) (((ns) * `MDFS_CLK_MHZ + 999) / 1000)
`define MDFS_CYC_DN(ns) (((ns) * `MDFS_CLK_MHZ) / 1000)
`define MDFS_OCP_FILTER_NS 1000
`define MDFS_RETRY_NS 4000
`define MDFS_OPEN_LOAD_NS 2000
`define MDFS_DEGLITCH_NS 5000
`define MDFS_SLEEP_NS 20000
`define MDFS_OCP_CYC `MDFS_CYC_UP(`MDFS_OCP_FILTER_NS)
`define MDFS_RETRY_CYC `MDFS_CYC_UP(`MDFS_RETRY_NS)
`define MDFS_OPEN_LOAD_CYC `MDFS_CYC_UP(`MDFS_OPEN_LOAD_NS)
`define MDFS_DEGLITCH_CYC `MDFS_CYC_UP(`MDFS_DEGLITCH_NS)
`define MDFS_SLEEP_CYC `MDFS_CYC_DN(`MDFS_SLEEP_NS)

`endif

/* pkg/mdfs_pkg.sv */
`default_nettype none

package mdfs_pkg;

  typedef logic [11:0] mdfs_cnt_t;

  typedef enum logic [1:0] {SLP_AWAKE, SLP_LOW, SLP_ASLEEP} mdfs_sleep_e;

  // Analog comparator and pin levels; limits one bit per FET, winding lows one bit per winding
  typedef struct packed {
    logic supply_low;
    logic reset_low;
    logic pump_low;
    logic [7:0] cur_lim;
    logic [1:0] wind_low;
    logic thermal_shutdown_flag;
    logic overheat_warning_flag;
    logic undertemp_warning_flag;
    logic pin;
  } mdfs_in_s;

  typedef struct packed {
    mdfs_in_s in1;
    mdfs_in_s in2;
    logic [3:0] ctrl;
    logic clr;
    logic uv;
    logic pump_low_flag;
    logic thermal_shutdown_flag;
    logic overheat_warning_flag;
    logic undertemp_warning_flag;
    logic [1:0] ol;
    logic [7:0] overcurrent_flag;
    logic [7:0][11:0] ocp_cnt;
    logic [1:0] ocp_off;
    logic [1:0][11:0] retry_cnt;
    logic [1:0][11:0] ol_cnt;
    logic ots_off;
    logic fault;
    logic [1:0] bridge_en;
    logic pump_en;
    logic [7:0] rdata;
  } mdfs_state_s;

  typedef struct packed {
    logic sync1;
    logic sync2;
    mdfs_sleep_e st;
    logic [11:0] cnt;
    logic clear_pulse;
    logic asleep;
  } mdfs_sleep_s;

endpackage

`default_nettype wire

/* pkg/mdfs_sleep_if.sv */
`default_nettype none

interface mdfs_sleep_if;
  logic clear_pulse;
  logic asleep;
  modport filt (output clear_pulse, output asleep);
  modport sup (input clear_pulse, input asleep);
endinterface

`default_nettype wire

/* hw/mdfs_sleep_filt.sv */
`include "mdfs_map.svh"
`default_nettype none

module mdfs_sleep_filt (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic sleep_n_in,
  mdfs_sleep_if.filt sl
);

  mdfs_pkg::mdfs_sleep_s s;
  mdfs_pkg::mdfs_sleep_s n;

  // ----------------------------------------
  // Low-time measurement of the sleep pin
  // ----------------------------------------
  // Short lows are glitches, mid lows are a clear pulse, long lows mean sleep
  always_comb begin
    n = s;
    n.sync1 = sleep_n_in;
    n.sync2 = s.sync1;
    n.clear_pulse = 1'b0;
    case (s.st)
      mdfs_pkg::SLP_AWAKE: begin
        if (!s.sync2) begin
          n.st = mdfs_pkg::SLP_LOW;
          n.cnt = 12'h000;
        end
      end
      mdfs_pkg::SLP_LOW: begin
        if (s.sync2) begin
          n.st = mdfs_pkg::SLP_AWAKE;
          n.clear_pulse = (s.cnt >= 12'(`MDFS_DEGLITCH_CYC));
        end else if (s.cnt == 12'(`MDFS_SLEEP_CYC - 1)) begin
          n.st = mdfs_pkg::SLP_ASLEEP;
          n.asleep = 1'b1;
        end else begin
          n.cnt = s.cnt + 12'h001;
        end
      end
      mdfs_pkg::SLP_ASLEEP: begin
        if (s.sync2) begin
          n.st = mdfs_pkg::SLP_AWAKE;
          n.asleep = 1'b0;
        end
      end
      default: begin
        n.st = mdfs_pkg::SLP_AWAKE;
      end
    endcase
  end

  // Pin assumed high through reset so no false clear is seen
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s <= '{sync1: 1'b1, sync2: 1'b1, st: mdfs_pkg::SLP_AWAKE, cnt: 12'h000,
             clear_pulse: 1'b0, asleep: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign sl.clear_pulse = s.clear_pulse;
  assign sl.asleep = s.asleep;

endmodule

`default_nettype wire

/* hw/mdfs_top.sv */
// Functional notes
// - Supply low: bridges and pump off, pin low, fault and supply flags set.
// - Supply back: drive and pin restored; supply flag held until cleared.
// - Supply flag is set out of reset until cleared.
// - Register port works in undervoltage, stops below logic-reset level.
// - Pump low: bridges off, pump stays on, pin low, pump flag set.
// - Pump back: drive and pin restored; pump flag held until cleared.
// - Pump flag is set out of reset until cleared.
// - Current limit past filter time disables that bridge, pin low, flags set.
// - One overcurrent flag per FET, low-side and high-side separately.
// - Retry select 0: bridge stays off until sleep pin cycle or reset.
// - Retry select 1: bridge returns after retry wait once limit gone.
// - Open load enabled and winding low past open-load time sets flags, pin low.
// - Open-load flags kept per winding A and B.
// - Open load released only by clear with condition gone, or sleep.
// - Shutdown temperature: bridges and pump off, pin low, flags set, always on.
// - Recovery select 0: stays shut down until sleep cycle or reset.
// - Recovery select 1: resumes on cooling; thermal flags held until clear.
// - Hot warning sets warning and temperature flags, clears by itself.
// - Warning report enable puts active warnings on pin and fault flag.
// - Cold warning sets warning and temperature flags, clears by itself.
// - Status byte carries supply, pump, overcurrent, temperature, open-load.
`include "mdfs_map.svh"
`default_nettype none

module mdfs_top (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic [3:0] BUS_ADDR_IN,
  input wire logic [7:0] BUS_WDATA_IN,
  input wire logic BUS_WRITE_IN,
  input wire logic BUS_READ_IN,
  output logic [7:0] BUS_RDATA_OUT,
  input wire logic SUPPLY_LOW_IN,
  input wire logic SUPPLY_RESET_LOW_IN,
  input wire logic PUMP_LOW_IN,
  input wire logic [7:0] CURRENT_LIMIT_IN,
  input wire logic [1:0] WINDING_LOW_IN,
  input wire logic DIE_SHUTDOWN_IN,
  input wire logic DIE_HOT_WARN_IN,
  input wire logic DIE_COLD_WARN_IN,
  input wire logic SLEEP_PIN_N_IN,
  input wire logic FAULT_INDICATOR_PIN_IN,
  output logic FAULT_INDICATOR_PIN_OUT,
  output logic FAULT_INDICATOR_PIN_OE_OUT,
  output logic [1:0] BRIDGE_ENABLE_OUT,
  output logic PUMP_ENABLE_OUT
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Saturating count, so a long fault never wraps back to idle
  function automatic logic [11:0] sat_inc(input logic [11:0] v, input logic [11:0] lim);
    sat_inc = (v >= lim) ? lim : v + 12'h001;
  endfunction

  // Sticky flag update; set wins over clear
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = (cur & ~clr) | set;
  endfunction

  mdfs_pkg::mdfs_state_s s;
  mdfs_pkg::mdfs_state_s n;
  mdfs_pkg::mdfs_in_s in_raw;
  mdfs_sleep_if sl ();

  logic bus_ok;
  logic clear_any;
  logic release_hw;
  logic [1:0] bridge_lim;
  logic [7:0] misc_byte;
  logic [7:0] status_byte;

  // ----------------------------------------
  // Sleep pin filter
  // ----------------------------------------
  mdfs_sleep_filt u_sleep (
    .clk_in(CLK_IN),
    .reset_in(RESET_IN),
    .sleep_n_in(SLEEP_PIN_N_IN),
    .sl(sl.filt)
  );

  // Comparator levels gathered for one synchroniser
  assign in_raw = {SUPPLY_LOW_IN, SUPPLY_RESET_LOW_IN, PUMP_LOW_IN, CURRENT_LIMIT_IN,
                   WINDING_LOW_IN, DIE_SHUTDOWN_IN, DIE_HOT_WARN_IN, DIE_COLD_WARN_IN,
                   FAULT_INDICATOR_PIN_IN};

  // Register port alive unless below logic reset or asleep
  assign bus_ok = ~s.in2.reset_low & ~sl.asleep;
  // Flag clears: software bit, sleep pulse, or sleep itself
  assign clear_any = s.clr | sl.clear_pulse | sl.asleep;
  // Latched shutdowns ignore the software clear; only the sleep pin frees them
  assign release_hw = sl.clear_pulse | sl.asleep;

  // Limit still active on either FET pair of a bridge
  assign bridge_lim[0] = |{s.in2.cur_lim[5:4], s.in2.cur_lim[1:0]};
  assign bridge_lim[1] = |{s.in2.cur_lim[7:6], s.in2.cur_lim[3:2]};

  // Status byte: fixed ones, then fault groups
  always_comb begin
    status_byte = 8'h00;
    status_byte[7:6] = `MDFS_ST_ONES;
    status_byte[`MDFS_ST_SUPPLY] = s.uv;
    status_byte[`MDFS_ST_PUMP] = s.pump_low_flag;
    status_byte[`MDFS_ST_OCP] = |s.overcurrent_flag;
    status_byte[`MDFS_ST_TEMP] = s.thermal_shutdown_flag | s.overheat_warning_flag | s.undertemp_warning_flag;
    status_byte[`MDFS_ST_OPEN] = |s.ol;
  end

  // Per-winding, thermal detail and summary fault
  assign misc_byte = {1'b0, s.in2.pin, s.fault, s.undertemp_warning_flag, s.overheat_warning_flag, s.thermal_shutdown_flag, s.ol};

  // ----------------------------------------
  // Supervisor next state
  // ----------------------------------------
  always_comb begin
    n = s;
    n.in1 = in_raw;
    n.in2 = s.in1;
    n.clr = 1'b0;
    n.rdata = 8'h00;

    // Register writes
    if (BUS_WRITE_IN && bus_ok && BUS_ADDR_IN == `MDFS_REG_CTRL) begin
      n.ctrl = BUS_WDATA_IN[3:0];
      n.clr = BUS_WDATA_IN[`MDFS_CTRL_CLEAR];
    end

    // Register reads, data in the next cycle only
    if (BUS_READ_IN && bus_ok) begin
      case (BUS_ADDR_IN)
        `MDFS_REG_CTRL: n.rdata = {4'h0, s.ctrl};
        `MDFS_REG_STATUS: n.rdata = status_byte;
        `MDFS_REG_OCP: n.rdata = s.overcurrent_flag;
        `MDFS_REG_MISC: n.rdata = misc_byte;
        default: n.rdata = 8'h00;
      endcase
    end

    // Supply and pump flags persist past the condition
    n.uv = sticky(s.uv, s.in2.supply_low, clear_any);
    n.pump_low_flag = sticky(s.pump_low_flag, s.in2.pump_low, clear_any);

    // Overcurrent filter and flags per FET
    for (int i = 0; i < 8; i++) begin
      if (s.in2.cur_lim[i]) begin
        n.ocp_cnt[i] = sat_inc(s.ocp_cnt[i], 12'(`MDFS_OCP_CYC));
      end else begin
        n.ocp_cnt[i] = 12'h000;
      end
      // Low bits are low-side FETs, high bits high-side FETs
      n.overcurrent_flag[i] = sticky(s.overcurrent_flag[i],
                        s.in2.cur_lim[i] && s.ocp_cnt[i] >= 12'(`MDFS_OCP_CYC),
                        clear_any);
    end

    // Bridge shutdown and recovery
    for (int b = 0; b < 2; b++) begin
      if (!s.ocp_off[b]) begin
        n.retry_cnt[b] = 12'h000;
      end else begin
        n.retry_cnt[b] = sat_inc(s.retry_cnt[b], 12'(`MDFS_RETRY_CYC));
      end
      if (s.ocp_off[b] && s.ctrl[`MDFS_CTRL_RETRY] && !bridge_lim[b] &&
          s.retry_cnt[b] >= 12'(`MDFS_RETRY_CYC)) begin
        n.ocp_off[b] = 1'b0;
      end else if (s.ocp_off[b] && release_hw) begin
        n.ocp_off[b] = 1'b0;
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (s.in2.cur_lim[i] && s.ocp_cnt[i] >= 12'(`MDFS_OCP_CYC)) begin
        n.ocp_off[(i >> 1) & 1] = 1'b1;
      end
    end

    // Open-load timing per winding while enabled and not asleep
    for (int w = 0; w < 2; w++) begin
      if (s.ctrl[`MDFS_CTRL_OL_EN] && s.in2.wind_low[w] && !sl.asleep) begin
        n.ol_cnt[w] = sat_inc(s.ol_cnt[w], 12'(`MDFS_OPEN_LOAD_CYC));
      end else begin
        n.ol_cnt[w] = 12'h000;
      end
      // Counter stays saturated, so a clear during the fault re-flags it
      n.ol[w] = sticky(s.ol[w], s.ol_cnt[w] >= 12'(`MDFS_OPEN_LOAD_CYC),
                       clear_any);
    end

    // Thermal shutdown, cannot be masked by any control bit
    n.thermal_shutdown_flag = sticky(s.thermal_shutdown_flag, s.in2.thermal_shutdown_flag, clear_any);
    if (s.in2.thermal_shutdown_flag) begin
      n.ots_off = 1'b1;
    end else if (s.ctrl[`MDFS_CTRL_RECOVER]) begin
      n.ots_off = 1'b0;
    end else if (release_hw) begin
      n.ots_off = 1'b0;
    end

    // Warnings follow the comparators with their own hysteresis
    n.overheat_warning_flag = s.in2.overheat_warning_flag;
    n.undertemp_warning_flag = s.in2.undertemp_warning_flag;

    // Drive enables
    n.pump_en = ~s.in2.supply_low & ~n.ots_off & ~sl.asleep;
    for (int b = 0; b < 2; b++) begin
      n.bridge_en[b] = ~s.in2.supply_low & ~s.in2.pump_low & ~n.ocp_off[b] &
                       ~n.ots_off & ~sl.asleep;
    end

    // Summary fault from what the pin reports
    n.fault = s.in2.supply_low | s.in2.pump_low | (|n.ocp_off) | (|n.ol) | n.ots_off |
              (s.ctrl[`MDFS_CTRL_WARN_REP] & (n.overheat_warning_flag | n.undertemp_warning_flag));
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Supply and pump flags come up set, as after a power ramp
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      s <= '0;
      s.ctrl <= `MDFS_CTRL_RESET;
      s.uv <= 1'b1;
      s.pump_low_flag <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign BUS_RDATA_OUT = s.rdata;
  assign FAULT_INDICATOR_PIN_OUT = 1'b0;
  assign FAULT_INDICATOR_PIN_OE_OUT = s.fault;
  assign BRIDGE_ENABLE_OUT = s.bridge_en;
  assign PUMP_ENABLE_OUT = s.pump_en;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_supply_low;
    @(posedge CLK_IN) disable iff (RESET_IN)
    s.in2.supply_low |=> (s.bridge_en == 2'b00 && !s.pump_en && s.uv && s.fault);
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("supply low not handled");

  property p_supply_back;
    @(posedge CLK_IN) disable iff (RESET_IN)
    (!s.in2.supply_low && !s.in2.pump_low && !sl.asleep) ##1 (s.ocp_off == 2'b00 && !s.ots_off)
      |-> s.bridge_en == 2'b11;
  endproperty
  a_supply_back: assert property (p_supply_back) else $error("drive not restored");

  property p_power_up;
    @(posedge CLK_IN) $fell(RESET_IN) |-> (s.uv && s.pump_low_flag);
  endproperty
  a_power_up: assert property (p_power_up) else $error("flags not set after reset");

  property p_status_read;
    @(posedge CLK_IN) disable iff (RESET_IN)
    (BUS_READ_IN && bus_ok && BUS_ADDR_IN == `MDFS_REG_STATUS)
      |=> (BUS_RDATA_OUT[7:6] == 2'b11 && BUS_RDATA_OUT[`MDFS_ST_SUPPLY] == $past(s.uv));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_reset_low_bus;
    @(posedge CLK_IN) disable iff (RESET_IN)
    (BUS_READ_IN && s.in2.reset_low) |=> BUS_RDATA_OUT == 8'h00;
  endproperty
  a_reset_low_bus: assert property (p_reset_low_bus) else $error("bus active below reset");

  property p_pump_low;
    @(posedge CLK_IN) disable iff (RESET_IN)
    (s.in2.pump_low && !s.in2.supply_low && !s.in2.thermal_shutdown_flag && !s.ots_off && !sl.asleep)
      |=> (s.bridge_en == 2'b00 && s.pump_en && s.pump_low_flag);
  endproperty
  a_pump_low: assert property (p_pump_low) else $error("pump low not handled");

  property p_ocp_trip;
    @(posedge CLK_IN) disable iff (RESET_IN)
    (s.in2.cur_lim[0] && s.ocp_cnt[0] == 12'(`MDFS_OCP_CYC))
      |=> (s.ocp_off[0] && s.overcurrent_flag[0] && s.bridge_en[0] == 1'b0 && s.fault);
  endproperty
  a_ocp_trip: assert property (p_ocp_trip) else $error("overcurrent not tripped");

  property p_ocp_latched;
    @(posedge CLK_IN) disable iff (RESET_IN)
    (s.ocp_off != 2'b00 && !s.ctrl[`MDFS_CTRL_RETRY] && !release_hw)
      |=> ((s.ocp_off & $past(s.ocp_off)) == $past(s.ocp_off));
  endproperty
  a_ocp_latched: assert property (p_ocp_latched) else $error("latched bridge released");

  property p_ots;
    @(posedge CLK_IN) disable iff (RESET_IN)
    s.in2.thermal_shutdown_flag |=> (!s.pump_en && s.bridge_en == 2'b00 && s.thermal_shutdown_flag && s.fault);
  endproperty
  a_ots: assert property (p_ots) else $error("thermal shutdown not handled");

  property p_clear_refire;
    @(posedge CLK_IN) disable iff (RESET_IN)
    (s.clr && s.in2.supply_low) |=> s.uv;
  endproperty
  a_clear_refire: assert property (p_clear_refire) else $error("active fault hidden");

  property p_warn_report;
    @(posedge CLK_IN) disable iff (RESET_IN)
    (s.in2.overheat_warning_flag && s.ctrl[`MDFS_CTRL_WARN_REP]) ##1 s.ctrl[`MDFS_CTRL_WARN_REP]
      |-> (s.overheat_warning_flag && s.fault && FAULT_INDICATOR_PIN_OE_OUT);
  endproperty
  a_warn_report: assert property (p_warn_report) else $error("warning not reported");

endmodule

`default_nettype wire

/* tb/mdfs_mcu.sv */
`default_nettype none

module mdfs_mcu (
  input wire logic clk_in,
  input wire logic pin_oe_in,
  input wire logic pin_out_in,
  output logic pin_level_out,
  output logic sleep_n_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Controller side of the fault pin and sleep pin
  // ----------------------------------------
  // Pull-up holds the open-drain line high unless the block pulls it down
  assign pin_level_out = pin_oe_in ? pin_out_in : 1'b1;

  initial sleep_n_out = 1'b1;

  // Short low pulse on the sleep pin clears latched faults without sleeping
  task automatic sleep_pulse(input int cycles);
    @(posedge clk_in);
    sleep_n_out <= 1'b0;
    repeat (cycles) @(posedge clk_in);
    sleep_n_out <= 1'b1;
  endtask
endmodule

`default_nettype wire

/* tb/testbench.sv */
`include "mdfs_map.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam logic [3:0] CT = `MDFS_REG_CTRL;
  localparam logic [3:0] ST = `MDFS_REG_STATUS;
  localparam logic [3:0] OC = `MDFS_REG_OCP;
  localparam logic [3:0] MI = `MDFS_REG_MISC;
  logic clk, rst, wr, rd, sup_low, rst_low, pump_low, thermal_shutdown_flag, overheat_warning_flag, undertemp_warning_flag;
  logic sleep_n, pin, pin_out, pin_oe, pump;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, cur_lim, v;
  logic [1:0] wind_low, bridge;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  mdfs_top u_mdfs_top (.CLK_IN(clk), .RESET_IN(rst), .BUS_ADDR_IN(addr), .BUS_WDATA_IN(wdata),
    .BUS_WRITE_IN(wr), .BUS_READ_IN(rd), .BUS_RDATA_OUT(rdata), .SUPPLY_LOW_IN(sup_low),
    .SUPPLY_RESET_LOW_IN(rst_low), .PUMP_LOW_IN(pump_low), .CURRENT_LIMIT_IN(cur_lim),
    .WINDING_LOW_IN(wind_low), .DIE_SHUTDOWN_IN(thermal_shutdown_flag), .DIE_HOT_WARN_IN(overheat_warning_flag),
    .DIE_COLD_WARN_IN(undertemp_warning_flag), .SLEEP_PIN_N_IN(sleep_n), .FAULT_INDICATOR_PIN_IN(pin),
    .FAULT_INDICATOR_PIN_OUT(pin_out), .FAULT_INDICATOR_PIN_OE_OUT(pin_oe),
    .BRIDGE_ENABLE_OUT(bridge), .PUMP_ENABLE_OUT(pump));

  mdfs_mcu u_mdfs_mcu (.clk_in(clk), .pin_oe_in(pin_oe), .pin_out_in(pin_out),
    .pin_level_out(pin), .sleep_n_out(sleep_n));

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // Hang guard; the full run needs well under ten thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      final_report();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Lets the edge's updates land before anything is sampled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
    bus_rd(a);
    chk(name, v, exp);
  endtask

  // Order: supply, pump, shutdown, hot, cold, winding B:A, limits
  task automatic set_in(input logic [14:0] x);
    @(posedge clk);
    {sup_low, pump_low, thermal_shutdown_flag, overheat_warning_flag, undertemp_warning_flag, wind_low, cur_lim} <= x;
  endtask

  // Packs bridges, pump and pin enable; pin level and summary fault must follow the enable
  task automatic outs(input logic [7:0] exp);
    chk("outputs", {4'h0, bridge, pump, pin_oe}, exp);
    bus_rd(MI);
    chk("pin", {7'h00, v[6]}, {7'h00, ~exp[0]});
    chk("summary", {7'h00, v[5]}, {7'h00, exp[0]});
  endtask

  task automatic clear(input logic [7:0] mode);
    bus_wr(CT, mode | 8'h10);
    tick(2);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk("status", ST, 8'hF0);
    outs(8'h0E);
    bus_wr(4'h9, 8'hFF);
    rd_chk("unmapped", 4'h9, 8'h00);
    clear(8'h00);
    rd_chk("status", ST, 8'hC0);
    rd_chk("ctrl", CT, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_supply();
    set_in(15'h4000);
    tick(5);
    outs(8'h01);
    rd_chk("status", ST, 8'hE0);
    clear(8'h00);
    rd_chk("status", ST, 8'hE0);
    set_in(15'h0000);
    tick(5);
    outs(8'h0E);
    rd_chk("status", ST, 8'hE0);
    clear(8'h00);
    @(posedge clk);
    rst_low <= 1'b1;
    tick(5);
    rd_chk("status", ST, 8'h00);
    @(posedge clk);
    rst_low <= 1'b0;
    tick(5);
    rd_chk("status", ST, 8'hC0);
    $display("test supply done");
  endtask

  task automatic t_pump();
    set_in(15'h2000);
    tick(5);
    outs(8'h03);
    rd_chk("status", ST, 8'hD0);
    set_in(15'h0000);
    tick(5);
    outs(8'h0E);
    rd_chk("status", ST, 8'hD0);
    clear(8'h00);
    rd_chk("status", ST, 8'hC0);
    $display("test pump done");
  endtask

  task automatic t_ocp();
    set_in(15'h0001);
    tick(50);
    set_in(15'h0000);
    tick(5);
    outs(8'h0E);
    set_in(15'h0001);
    tick(150);
    set_in(15'h0000);
    tick(5);
    outs(8'h0B);
    rd_chk("status", ST, 8'hC8);
    rd_chk("ocp", OC, 8'h01);
    tick(600);
    outs(8'h0B);
    clear(8'h00);
    outs(8'h0B);
    u_mdfs_mcu.sleep_pulse(1000);
    tick(10);
    outs(8'h0E);
    clear(8'h01);
    set_in(15'h0040);
    tick(150);
    outs(8'h07);
    rd_chk("ocp", OC, 8'h40);
    set_in(15'h0000);
    tick(100);
    outs(8'h07);
    tick(400);
    outs(8'h0E);
    clear(8'h00);
    $display("test overcurrent done");
  endtask

  task automatic t_open();
    set_in(15'h0100);
    tick(250);
    outs(8'h0E);
    set_in(15'h0000);
    clear(8'h04);
    set_in(15'h0200);
    tick(150);
    outs(8'h0E);
    tick(100);
    outs(8'h0F);
    rd_chk("misc", MI, 8'h22);
    rd_chk("status", ST, 8'hC1);
    set_in(15'h0000);
    tick(5);
    outs(8'h0F);
    clear(8'h04);
    outs(8'h0E);
    rd_chk("status", ST, 8'hC0);
    clear(8'h00);
    $display("test open load done");
  endtask

  task automatic t_thermal();
    set_in(15'h1000);
    tick(5);
    outs(8'h01);
    rd_chk("misc", MI, 8'h24);
    rd_chk("status", ST, 8'hC2);
    set_in(15'h0000);
    tick(10);
    outs(8'h01);
    u_mdfs_mcu.sleep_pulse(1000);
    tick(10);
    outs(8'h0E);
    clear(8'h02);
    set_in(15'h1000);
    tick(5);
    outs(8'h01);
    set_in(15'h0000);
    tick(5);
    outs(8'h0E);
    rd_chk("misc", MI, 8'h44);
    clear(8'h00);
    rd_chk("status", ST, 8'hC0);
    $display("test thermal done");
  endtask

  task automatic t_warn();
    for (int i = 0; i < 2; i++) begin
      set_in(i ? 15'h0400 : 15'h0800);
      tick(5);
      outs(8'h0E);
      rd_chk("status", ST, 8'hC2);
      rd_chk("misc", MI, i ? 8'h50 : 8'h48);
      bus_wr(CT, 8'h08);
      tick(5);
      outs(8'h0F);
      bus_wr(CT, 8'h00);
      set_in(15'h0000);
      tick(5);
      outs(8'h0E);
      rd_chk("status", ST, 8'hC0);
    end
    $display("test warnings done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {wr, rd, addr, wdata, rst_low} = '0;
    {sup_low, pump_low, thermal_shutdown_flag, overheat_warning_flag, undertemp_warning_flag, wind_low, cur_lim} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(5);
    t_reset();
    t_supply();
    t_pump();
    t_ocp();
    t_open();
    t_thermal();
    t_warn();
    final_report();
  end
endmodule

`default_nettype wire
